// ==== src/atf_pkg.sv ====
// package: register indices, field layouts, modes and states of the converter timing block
package atf_pkg;
    // ==========================================================
    // register indices (byte address is four times the index)
    localparam logic [13:0] IDX_FILT_L = 14'h1d14;
    localparam logic [13:0] IDX_FILT_H = 14'h1d15;
    localparam logic [13:0] IDX_RCNT = 14'h1d19;
    localparam logic [13:0] IDX_RLIM = 14'h1d1a;
    localparam logic [13:0] IDX_RES_L = 14'h1d1d;
    localparam logic [13:0] IDX_RES_H = 14'h1d1e;
    localparam logic [13:0] IDX_ACQ_L = 14'h1d21;
    localparam logic [13:0] IDX_ACQ_H = 14'h1d22;
    localparam logic [13:0] IDX_CAP = 14'h1d23;
    localparam logic [13:0] IDX_PRE_L = 14'h1d24;
    localparam logic [13:0] IDX_PRE_H = 14'h1d25;
    localparam logic [13:0] IDX_CTRL = 14'h1d30;
    localparam logic [13:0] IDX_STAT = 14'h1d31;
    // ==========================================================
    // field widths and positions
    localparam int LEN_W = 13;
    localparam int CAP_W = 5;
    localparam int SUM_W = 18;
    localparam int CTRL_SRC_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CTRL_SHIFT_LSB = 4;
    // ==========================================================
    // reset values, counts and bus encodings
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam int ACQ_ZERO_TICKS = 8192;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HRESP_OKAY = 2'h0;
    // ==========================================================
    // computation modes
    typedef enum logic [2:0] {
        ATF_BASIC = 3'h0,
        ATF_ACCUM = 3'h1,
        ATF_AVG = 3'h2,
        ATF_BURST = 3'h3,
        ATF_LOW_PASS = 3'h4
    } atf_mode_t;
    // sequencer phases
    typedef enum logic [1:0] {
        ATF_IDLE = 2'h0,
        ATF_PRE = 2'h1,
        ATF_ACQ = 2'h2,
        ATF_CONV = 2'h3
    } atf_state_t;
    // controls handed to the analog core
    typedef struct packed {
        logic precharge;
        logic acquire;
        logic convert_start;
        logic [CAP_W-1:0] added_farads_field;
        logic divider_enable;
    } atf_analog_t;
endpackage

// ==== src/atf_top.sv ====
// converter timing, repeat counting and filter registers behind an ahb-lite slave
//
// Function
// [RULE_01] 13-bit precharge length; zero skips precharge
// [RULE_02] 13-bit acquisition length counted in converter clocks
// [RULE_03] both zero: acquisition phase skipped
// [RULE_04] acquisition zero, precharge nonzero: 8192 clocks
// [RULE_05] count oscillator ticks when oscillator selected
// [RULE_06] 5-bit added capacitance, picofarads per step
// [RULE_07] 8-bit repeat limit triggers threshold check
// [RULE_08] 8-bit software-accessible trigger counter
// [RULE_09] counting only in filter, burst, average
// [RULE_10] accumulate modes: output is sum shifted right
// [RULE_11] low-pass mode: signed read-only filter output
// [RULE_12] 16-bit read/write result, reset to zero
// [RULE_13] multibyte registers reached byte by byte
// [RULE_14] source zero selects system clock and divider
// [RULE_15] running sum signed, sign-extended upper bits
// [RULE_16] counter increments per trigger, saturates or restarts
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
module atf_top
    import atf_pkg::*;
#(
    parameter int ACQ_DEFAULT = atf_pkg::ACQ_ZERO_TICKS // ticks when acquisition length is zero
) (
    input wire logic hclk, // system clock, 125 MHz
    input wire logic hresetn, // asynchronous reset, active low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size, word only
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // slave ready
    output logic [1:0] hresp, // always okay
    input wire logic conv_trigger, // start a conversion, one-cycle pulse
    input wire logic osc_tick, // one pulse per converter oscillator clock
    input wire logic conv_done, // analog core finished, one-cycle pulse
    input wire logic [15:0] conv_data, // signed sample from the core
    output atf_pkg::atf_analog_t analog, // controls to the analog core
    output logic threshold_check // repeat limit reached, one-cycle pulse
);
    import atf_pkg::*;

    // ==========================================================
    // bus slave
    logic pend; // data phase owed
    logic pend_wr; // owed phase is a write
    logic [13:0] pend_idx; // register index of owed phase
    wire accept = hsel && hready && hreadyout && (htrans == HTRANS_NONSEQ);
    wire do_wr = pend && pend_wr;
    wire [7:0] wb = hwdata[7:0];
    // per-byte write strobes, one per access name
    wire wr_rcnt = do_wr && (pend_idx == IDX_RCNT);
    wire wr_rlim = do_wr && (pend_idx == IDX_RLIM);
    wire wr_res_l = do_wr && (pend_idx == IDX_RES_L);
    wire wr_res_h = do_wr && (pend_idx == IDX_RES_H);
    wire wr_acq_l = do_wr && (pend_idx == IDX_ACQ_L);
    wire wr_acq_h = do_wr && (pend_idx == IDX_ACQ_H);
    wire wr_cap = do_wr && (pend_idx == IDX_CAP);
    wire wr_pre_l = do_wr && (pend_idx == IDX_PRE_L);
    wire wr_pre_h = do_wr && (pend_idx == IDX_PRE_H);
    wire wr_ctrl = do_wr && (pend_idx == IDX_CTRL);

    // the data phase always costs one wait state so hrdata can come from a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend <= 1'b0;
            pend_wr <= 1'b0;
            pend_idx <= 14'h0000;
            hreadyout <= 1'b1;
        end else begin
            pend <= accept;
            hreadyout <= !accept;
            if (accept) begin
                pend_wr <= hwrite;
                pend_idx <= haddr[15:2];
            end
        end
    end
    assign hresp = HRESP_OKAY;

    // ==========================================================
    // software registers
    logic [LEN_W-1:0] bias_phase_length; // precharge length
    logic [LEN_W-1:0] acquisition_length; // acquisition length
    logic [CAP_W-1:0] added_sampling_farads; // extra capacitance
    logic [7:0] repeat_limit; // repeat limit field
    logic [7:0] repeat_counter; // trigger tally
    logic [15:0] sample_outcome; // sample result
    logic [15:0] filter_output; // filtered value
    logic clk_src; // 1 selects the dedicated oscillator
    logic [2:0] mode_bits; // computation mode
    logic [2:0] sum_shift_amount; // right shift of the running sum
    wire atf_mode_t mode = atf_mode_t'(mode_bits);

    // timing fields keep only their documented bits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bias_phase_length <= 13'h0000;
            acquisition_length <= 13'h0000;
            added_sampling_farads <= 5'h00;
            repeat_limit <= RST_BYTE;
            clk_src <= 1'b0;
            mode_bits <= 3'h0;
            sum_shift_amount <= 3'h0;
        end else begin
            if (wr_pre_l) bias_phase_length[7:0] <= wb; // RULE_01 RULE_13
            if (wr_pre_h) bias_phase_length[12:8] <= wb[4:0]; // RULE_01 RULE_13
            if (wr_acq_l) acquisition_length[7:0] <= wb; // RULE_02 RULE_13
            if (wr_acq_h) acquisition_length[12:8] <= wb[4:0]; // RULE_02 RULE_13
            if (wr_cap) added_sampling_farads <= wb[CAP_W-1:0]; // RULE_06
            if (wr_rlim) repeat_limit <= wb; // RULE_07
            if (wr_ctrl) begin
                clk_src <= wb[CTRL_SRC_BIT];
                mode_bits <= wb[CTRL_MODE_LSB +: 3];
                sum_shift_amount <= wb[CTRL_SHIFT_LSB +: 3];
            end
        end
    end

    // ==========================================================
    // conversion sequencer
    atf_state_t state; // current phase
    logic [LEN_W:0] ph_cnt; // ticks left in the phase
    // system clock counts every edge; the oscillator only on its ticks
    wire tick = clk_src ? osc_tick : 1'b1; // RULE_05
    wire start = (state == ATF_IDLE) && conv_trigger;
    wire ph_end = tick && (ph_cnt == 14'h0001);
    wire pre_on = (bias_phase_length != 13'h0000);
    wire acq_on = (acquisition_length != 13'h0000);
    // zero acquisition after a precharge stretches to the long default
    wire [LEN_W:0] acq_load = acq_on ? {1'b0, acquisition_length}
                                     : ACQ_DEFAULT[LEN_W:0]; // RULE_04
    wire finish = (state == ATF_CONV) && conv_done;

    // precharge and acquisition load their length on entry and count down on ticks
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ATF_IDLE;
            ph_cnt <= 14'h0000;
        end else begin
            case (state)
                ATF_IDLE: begin
                    if (start && pre_on) begin // RULE_01
                        state <= ATF_PRE;
                        ph_cnt <= {1'b0, bias_phase_length};
                    end else if (start && acq_on) begin // RULE_02
                        state <= ATF_ACQ;
                        ph_cnt <= acq_load;
                    end else if (start) begin // RULE_03
                        state <= ATF_CONV;
                    end
                end
                ATF_PRE: begin
                    if (ph_end) begin // RULE_04
                        state <= ATF_ACQ;
                        ph_cnt <= acq_load;
                    end else if (tick) begin
                        ph_cnt <= ph_cnt - 14'h0001;
                    end
                end
                ATF_ACQ: begin
                    if (ph_end) begin
                        state <= ATF_CONV;
                    end else if (tick) begin
                        ph_cnt <= ph_cnt - 14'h0001;
                    end
                end
                ATF_CONV: begin
                    if (conv_done) state <= ATF_IDLE;
                end
                default: state <= ATF_IDLE;
            endcase
        end
    end

    // ==========================================================
    // repeat counting and computation
    wire counts = (mode == ATF_LOW_PASS) || (mode == ATF_BURST) || (mode == ATF_AVG); // RULE_09
    wire [7:0] cnt_inc = repeat_counter + 8'h01;
    wire at_limit = start && counts && (cnt_inc == repeat_limit);
    logic signed [SUM_W-1:0] running_sum; // signed running sum
    wire signed [SUM_W-1:0] sample_ext = {{(SUM_W-16){conv_data[15]}}, conv_data}; // RULE_15
    wire signed [SUM_W-1:0] sum_shr = running_sum >>> sum_shift_amount;
    // low-pass keeps a leaky sum; the others add plainly
    wire signed [SUM_W-1:0] next_sum = (mode == ATF_LOW_PASS) ?
        running_sum - sum_shr + sample_ext : running_sum + sample_ext;

    // a trigger increment beats a software write in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            repeat_counter <= RST_BYTE;
            threshold_check <= 1'b0;
        end else begin
            threshold_check <= at_limit; // RULE_07
            if (start && counts) begin // RULE_08 RULE_16
                // low-pass holds at the limit, average and burst start over
                if (at_limit && mode != ATF_LOW_PASS) repeat_counter <= RST_BYTE;
                else if (repeat_counter != repeat_limit) repeat_counter <= cnt_inc;
            end else if (wr_rcnt) begin
                repeat_counter <= wb; // RULE_08
            end
        end
    end

    // sum and result move on conversion end; the result wins over a software write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            running_sum <= 18'h00000;
            sample_outcome <= RST_WORD;
            filter_output <= RST_WORD;
        end else begin
            if (finish && mode != ATF_BASIC) running_sum <= next_sum; // RULE_15
            if (finish) sample_outcome <= conv_data; // RULE_12
            else if (wr_res_l) sample_outcome[7:0] <= wb; // RULE_12 RULE_13
            else if (wr_res_h) sample_outcome[15:8] <= wb; // RULE_12 RULE_13
            filter_output <= sum_shr[15:0]; // RULE_10 RULE_11
        end
    end

    // ==========================================================
    // outputs to the analog core and read mux
    wire [7:0] stat = {6'h00, state};
    wire [7:0] ctrl = {1'b0, sum_shift_amount, mode_bits, clk_src};
    wire [7:0] rd_byte =
        (pend_idx == IDX_FILT_L) ? filter_output[7:0] :
        (pend_idx == IDX_FILT_H) ? filter_output[15:8] :
        (pend_idx == IDX_RCNT) ? repeat_counter :
        (pend_idx == IDX_RLIM) ? repeat_limit :
        (pend_idx == IDX_RES_L) ? sample_outcome[7:0] :
        (pend_idx == IDX_RES_H) ? sample_outcome[15:8] :
        (pend_idx == IDX_ACQ_L) ? acquisition_length[7:0] :
        (pend_idx == IDX_ACQ_H) ? {3'h0, acquisition_length[12:8]} :
        (pend_idx == IDX_CAP) ? {3'h0, added_sampling_farads} :
        (pend_idx == IDX_PRE_L) ? bias_phase_length[7:0] :
        (pend_idx == IDX_PRE_H) ? {3'h0, bias_phase_length[12:8]} :
        (pend_idx == IDX_CTRL) ? ctrl :
        (pend_idx == IDX_STAT) ? stat : 8'h00;

    // analog controls are registered so they never glitch into the core
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            analog <= '0;
            hrdata <= 32'h00000000;
        end else begin
            analog.precharge <= (state == ATF_PRE);
            analog.acquire <= (state == ATF_ACQ);
            analog.convert_start <= (state == ATF_ACQ && ph_end) ||
                                    (start && !pre_on && !acq_on);
            analog.added_farads_field <= added_sampling_farads; // RULE_06
            analog.divider_enable <= !clk_src; // RULE_14
            if (pend && !pend_wr) hrdata <= {24'h000000, rd_byte}; // RULE_13
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_pre_load;
        start && pre_on |=> state == ATF_PRE && ph_cnt == {1'b0, $past(bias_phase_length)};
    endproperty
    a_pre_load: assert property (p_pre_load) else $error("precharge not loaded"); // RULE_01
    property p_skip_both;
        start && !pre_on && !acq_on |=> state == ATF_CONV && analog.convert_start;
    endproperty
    a_skip_both: assert property (p_skip_both) else $error("empty phases not skipped"); // RULE_03
    property p_acq_default;
        state == ATF_PRE && ph_end && !acq_on |=> state == ATF_ACQ && ph_cnt == ACQ_DEFAULT;
    endproperty
    a_acq_default: assert property (p_acq_default) else $error("default acquisition wrong"); // RULE_04
    property p_hold;
        (state == ATF_PRE || state == ATF_ACQ) && !tick |=> $stable(ph_cnt);
    endproperty
    a_hold: assert property (p_hold) else $error("phase counted without tick"); // RULE_05
    property p_cap;
        ##1 analog.added_farads_field == $past(added_sampling_farads);
    endproperty
    a_cap: assert property (p_cap) else $error("capacitance not forwarded"); // RULE_06
    property p_limit;
        start && counts && cnt_inc == repeat_limit |=> threshold_check;
    endproperty
    a_limit: assert property (p_limit) else $error("threshold check missed"); // RULE_07
    property p_no_count;
        start && !counts && !wr_rcnt |=> $stable(repeat_counter) && !threshold_check;
    endproperty
    a_no_count: assert property (p_no_count) else $error("counted in wrong mode"); // RULE_09
    property p_filter;
        ##1 filter_output == $past(sum_shr[15:0]);
    endproperty
    a_filter: assert property (p_filter) else $error("filter output wrong"); // RULE_10
    property p_result;
        finish |=> sample_outcome == $past(conv_data);
    endproperty
    a_result: assert property (p_result) else $error("result not captured"); // RULE_12
    property p_bus;
        accept |=> !hreadyout ##1 hreadyout;
    endproperty
    a_bus: assert property (p_bus) else $error("bus wait state wrong"); // RULE_13
endmodule

// ==== dv/tb.sv ====
// self-checking testbench for the converter timing and filter register block
`timescale 1ns/1ps
module tb;
    import atf_pkg::*;
    // ==========================================================
    // stimulus and observation signals
    localparam int ACQ_SMALL = 16; // shortened zero-acquisition count
    logic hclk = 1'b0; // system clock
    logic hresetn = 1'b0; // active-low reset
    logic hsel = 1'b0; // slave select
    logic [31:0] haddr = 32'h0; // byte address
    logic [1:0] htrans = 2'h0; // transfer type
    logic hwrite = 1'b0; // write strobe
    logic [31:0] hwdata = 32'h0; // write data
    logic [31:0] hrdata; // read data
    logic hreadyout; // slave ready, fed back as hready
    logic [1:0] hresp; // response
    logic conv_trigger = 1'b0; // conversion start pulse
    logic osc_tick = 1'b0; // oscillator tick pulse
    logic osc_en = 1'b0; // enables the tick generator
    logic [1:0] osc_div = 2'h0; // tick divider, one tick in four cycles
    logic conv_done = 1'b0; // core finished pulse
    logic [15:0] conv_data = 16'h0; // sample from the core
    atf_analog_t analog; // analog controls
    logic threshold_check; // limit reached pulse
    int failures = 0; // mismatch count
    int num_checks = 0; // comparison count
    int np, na, nt; // phase lengths and pulses of one conversion
    always #4 hclk = ~hclk;
    // slow oscillator stand-in, unrelated to bus traffic
    always @(posedge hclk) begin
        osc_div <= osc_div + 2'h1;
        osc_tick <= osc_en && (osc_div == 2'h3);
    end
    atf_top #(.ACQ_DEFAULT(ACQ_SMALL)) i_atf_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .conv_trigger(conv_trigger), .osc_tick(osc_tick), .conv_done(conv_done),
        .conv_data(conv_data), .analog(analog), .threshold_check(threshold_check));
    // ==========================================================
    // compare, report and bus tasks
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // four-state compare so an unknown count never slips through as a match
    task automatic chk_cnt(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // waits for the ready sampled high at a rising edge, bounded
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) failures++;
    endtask
    task automatic bus(input logic wr, input logic [13:0] idx, input logic [7:0] wd,
            output logic [7:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        haddr <= {16'h0000, idx, 2'b00};
        wait_ready();
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        wait_ready();
        rd = hrdata[7:0];
    endtask
    task automatic wr8(input logic [13:0] idx, input logic [7:0] d);
        logic [7:0] unused;
        bus(1'b1, idx, d, unused);
    endtask
    task automatic rd16(input logic [13:0] idx, output logic [15:0] v);
        bus(1'b0, idx, 8'h00, v[7:0]);
        bus(1'b0, idx + 14'h1, 8'h00, v[15:8]);
    endtask
    task automatic set_len(input logic [12:0] pre, input logic [12:0] sample_window_count);
        wr8(IDX_PRE_L, pre[7:0]);
        wr8(IDX_PRE_H, {3'h0, pre[12:8]});
        wr8(IDX_ACQ_L, sample_window_count[7:0]);
        wr8(IDX_ACQ_H, {3'h0, sample_window_count[12:8]});
    endtask
    task automatic ctrl(input logic src, input atf_mode_t m, input logic [2:0] sh);
        wr8(IDX_CTRL, {1'b0, sh, m, src});
    endtask
    task automatic do_reset();
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
    endtask
    // one conversion: trigger, phase counting, then the core's done pulse
    task automatic run(input logic [15:0] d);
        int n;
        n = 0;
        np = 0;
        na = 0;
        nt = 0;
        @(posedge hclk);
        conv_trigger <= 1'b1;
        @(posedge hclk);
        conv_trigger <= 1'b0;
        do begin
            @(posedge hclk);
            n++;
            np += int'(analog.precharge);
            na += int'(analog.acquire);
            nt += int'(threshold_check);
        end while (analog.convert_start !== 1'b1 && n < 20000);
        if (n >= 20000) failures++;
        conv_data <= d;
        conv_done <= 1'b1;
        @(posedge hclk);
        conv_done <= 1'b0;
        repeat (3) @(posedge hclk);
    endtask
    // ==========================================================
    // scenarios
    task automatic t_regs();
        logic [13:0] ix[10] = '{IDX_ACQ_L, IDX_ACQ_H, IDX_PRE_L, IDX_PRE_H, IDX_CAP,
            IDX_RLIM, IDX_RCNT, IDX_RES_L, IDX_RES_H, IDX_FILT_L};
        logic [7:0] wv[10] = '{8'hff, 8'hff, 8'ha5, 8'hff, 8'hff, 8'h5a, 8'hc3, 8'h34, 8'h12, 8'hff};
        logic [7:0] ev[10] = '{8'hff, 8'h1f, 8'ha5, 8'h1f, 8'h1f, 8'h5a, 8'hc3, 8'h34, 8'h12, 8'h00};
        logic [7:0] r;
        for (int i = 0; i < 10; i++) begin
            bus(1'b0, ix[i], 8'h00, r);
            chk_val({8'h0, r}, 16'h0000, "reset value");
        end
        bus(1'b0, 14'h1d00, 8'h00, r);
        chk_val({8'h0, r}, 16'h0000, "unmapped read");
        chk_val({14'h0, hresp}, {14'h0, HRESP_OKAY}, "okay response");
        for (int i = 0; i < 10; i++) begin
            wr8(ix[i], wv[i]);
            bus(1'b0, ix[i], 8'h00, r);
            chk_val({8'h0, r}, {8'h0, ev[i]}, "readback");
        end
        chk_val({11'h0, analog.added_farads_field}, 16'h001f, "cap out");
        wr8(IDX_CAP, 8'h00);
        // the analog copy is registered one edge behind the field
        @(posedge hclk);
        chk_val({11'h0, analog.added_farads_field}, 16'h0000, "cap none");
        $display("test registers done");
    endtask
    task automatic t_phases();
        logic [15:0] v;
        ctrl(1'b0, ATF_BASIC, 3'h0);
        set_len(13'h0002, 13'h0003);
        run(16'h0123);
        chk_cnt(np, 2, "precharge length");
        chk_cnt(na, 3, "acquire length");
        chk_val({15'h0, analog.divider_enable}, 16'h0001, "divider on");
        rd16(IDX_RES_L, v);
        chk_val(v, 16'h0123, "sample result");
        rd16(IDX_RCNT, v);
        chk_val({8'h0, v[7:0]}, 16'h00c3, "basic mode count");
        set_len(13'h0000, 13'h0000);
        run(16'h0);
        chk_cnt(np + na, 0, "both skipped");
        set_len(13'h0001, 13'h0000);
        run(16'h0);
        chk_cnt(na, ACQ_SMALL, "zero acquire default");
        set_len(13'h1fff, 13'h0001);
        run(16'h0);
        chk_cnt(np, 8191, "max precharge");
        ctrl(1'b1, ATF_BASIC, 3'h0);
        osc_en <= 1'b1;
        set_len(13'h0002, 13'h0002);
        run(16'h0);
        chk_cnt(int'(np >= 5 && np <= 8 && na >= 5 && na <= 8), 1, "osc counting");
        chk_val({15'h0, analog.divider_enable}, 16'h0000, "divider off");
        osc_en <= 1'b0;
        $display("test phases done");
    endtask
    task automatic t_repeat();
        atf_mode_t ms[3] = '{ATF_AVG, ATF_BURST, ATF_LOW_PASS};
        logic [15:0] v;
        set_len(13'h0000, 13'h0000);
        for (int i = 0; i < 3; i++) begin
            ctrl(1'b0, ms[i], 3'h0);
            wr8(IDX_RCNT, 8'h00);
            wr8(IDX_RLIM, 8'h02);
            run(16'h0);
            chk_cnt(nt, 0, "no check yet");
            run(16'h0);
            chk_cnt(nt, 1, "check at limit");
            rd16(IDX_RCNT, v);
            chk_val({8'h0, v[7:0]}, (i == 2) ? 16'h2 : 16'h0, "count at limit");
            run(16'h0);
            rd16(IDX_RCNT, v);
            chk_val({8'h0, v[7:0]}, (i == 2) ? 16'h2 : 16'h1, "count after");
        end
        $display("test repeat done");
    endtask
    task automatic t_filter();
        logic [15:0] v;
        do_reset();
        ctrl(1'b0, ATF_ACCUM, 3'h1);
        run(16'h0064);
        run(16'h0064);
        rd16(IDX_FILT_L, v);
        chk_val(v, 16'h0064, "accumulate shifted");
        ctrl(1'b0, ATF_BURST, 3'h2);
        run(16'hffd8);
        rd16(IDX_FILT_L, v);
        chk_val(v, 16'h0028, "burst shifted");
        do_reset();
        ctrl(1'b0, ATF_LOW_PASS, 3'h1);
        run(16'hfff8);
        wr8(IDX_FILT_L, 8'h55);
        rd16(IDX_FILT_L, v);
        chk_val(v, 16'hfffc, "low-pass signed");
        run(16'hfff8);
        rd16(IDX_FILT_L, v);
        chk_val(v, 16'hfffa, "low-pass step");
        $display("test filter done");
    endtask
    // ==========================================================
    // main sequence and watchdog
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_phases();
        t_repeat();
        t_filter();
        summarize();
    end
    initial begin
        #400000;
        failures++;
        summarize();
    end
endmodule
